// ---- design/cfrs_defines.svh ----
`ifndef CFRS_DEFINES_SVH
`define CFRS_DEFINES_SVH
// ****************************************
// I/O offsets and reset values
// ****************************************
`define CFRS_IO_SP_LOW 6'h3d
`define CFRS_IO_SP_HIGH 6'h3e
`define CFRS_IO_FLAGS 6'h3f
`define CFRS_SP_RESET 16'h0000
`define CFRS_FLAGS_RESET 8'h00
// ****************************************
// Flag bit positions
// ****************************************
`define CFRS_BIT_GATE 7
`define CFRS_BIT_COPY 6
`define CFRS_BIT_HALF 5
`define CFRS_BIT_SIGN 4
`define CFRS_BIT_OVF 3
`define CFRS_BIT_NEG 2
`define CFRS_BIT_ZERO 1
`define CFRS_BIT_CARRY 0
// ****************************************
// Register file map
// ****************************************
`define CFRS_GPR_LAST 8'h1f
`define CFRS_PTR_X 5'h1a
`define CFRS_PTR_Y 5'h1c
`define CFRS_PTR_Z 5'h1e
`endif

// ---- design/cfrs_pkg.sv ----
package cfrs_pkg;
	// Write-back scheme of the register file
	typedef enum logic [1:0] {
		CFRS_WB_NONE,
		CFRS_WB_BYTE,
		CFRS_WB_WORD
	} cfrs_wb_t;
	// Pointer addressing form
	typedef enum logic [1:0] {
		CFRS_PM_DISP,
		CFRS_PM_POSTINC,
		CFRS_PM_PREDEC
	} cfrs_pmode_t;
	// Stack pointer operation
	typedef enum logic [2:0] {
		CFRS_SP_HOLD,
		CFRS_SP_PUSH1,
		CFRS_SP_PUSH2,
		CFRS_SP_POP1,
		CFRS_SP_POP2
	} cfrs_spop_t;
endpackage

// ---- design/cfrs_stack.sv ----
`timescale 1ns/1ps
`include "cfrs_defines.svh"
module cfrs_stack (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire cfrs_pkg::cfrs_spop_t sp_op_i,
	input wire logic wr_low_i,
	input wire logic wr_high_i,
	input wire logic [7:0] wr_data_i,
	output logic [15:0] sp_o,
	output logic [15:0] stack_addr_o
);
	import cfrs_pkg::*;
	logic [15:0] sp_reg;
	logic [15:0] sp_next;
	// ****************************************
	// Downward-growing stack pointer
	// ****************************************
	always_comb begin
		sp_next = sp_reg;
		unique case (sp_op_i)
			CFRS_SP_HOLD: sp_next = sp_reg;
			CFRS_SP_PUSH1: sp_next = sp_reg - 16'h0001; // see RQ19
			CFRS_SP_PUSH2: sp_next = sp_reg - 16'h0002; // see RQ19
			CFRS_SP_POP1: sp_next = sp_reg + 16'h0001; // see RQ20
			CFRS_SP_POP2: sp_next = sp_reg + 16'h0002; // see RQ20
			default: sp_next = sp_reg;
		endcase
		if (wr_low_i) begin
			sp_next[7:0] = wr_data_i; // see RQ21
		end
		if (wr_high_i) begin
			sp_next[15:8] = wr_data_i; // see RQ21
		end
	end
	// Push writes at SP then decrements; one-byte pop increments then reads, two-byte pop addresses SP
	assign stack_addr_o = (sp_op_i == CFRS_SP_POP1) ? sp_reg + 16'h0001 : sp_reg; // see RQ23
	assign sp_o = sp_reg; // see RQ18
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sp_reg <= `CFRS_SP_RESET;
		end else begin
			sp_reg <= sp_next;
		end
	end
endmodule

// ---- design/cfrs_flags.sv ----
`timescale 1ns/1ps
`include "cfrs_defines.svh"
module cfrs_flags (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic alu_upd_i,
	input wire logic [7:0] alu_mask_i,
	input wire logic [7:0] alu_flags_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_data_i,
	input wire logic gate_set_i,
	input wire logic gate_clr_i,
	input wire logic irq_taken_i,
	input wire logic handler_exit_instr_i,
	input wire logic flag_capture_instr_i,
	input wire logic copy_bit_i,
	output logic [7:0] flags_o
);
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] merged;
	// ****************************************
	// Flag update
	// ****************************************
	// ALU writes only the flags its operation defines
	assign merged = (flags_reg & ~alu_mask_i) | (alu_flags_i & alu_mask_i); // see RQ1
	always_comb begin
		flags_next = flags_reg;
		if (io_wr_i) begin
			flags_next = io_data_i;
		end else if (alu_upd_i) begin
			flags_next = merged; // see RQ7, see RQ9, see RQ10, see RQ11, see RQ12
		end
		if (flag_capture_instr_i) begin
			flags_next[`CFRS_BIT_COPY] = copy_bit_i; // see RQ6
		end
		if (irq_taken_i || gate_clr_i) begin
			flags_next[`CFRS_BIT_GATE] = 1'b0; // see RQ4, see RQ5
		end else if (handler_exit_instr_i || gate_set_i) begin
			flags_next[`CFRS_BIT_GATE] = 1'b1; // see RQ4, see RQ5
		end
		// Sign is derived, never stored independently
		flags_next[`CFRS_BIT_SIGN] = flags_next[`CFRS_BIT_NEG] ^ flags_next[`CFRS_BIT_OVF]; // see RQ8
	end
	assign flags_o = flags_reg;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flags_reg <= `CFRS_FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end
endmodule

// ---- design/cfrs_core.sv ----
`timescale 1ns/1ps
`include "cfrs_defines.svh"
// Summary of operation
// RQ1: Flags refresh after each ALU operation using the ALU's flag mask.
// RQ2: Flags are never saved or restored on interrupts; software does it.
// RQ3: Global gate bit clear blocks all interrupt requests.
// RQ4: Taking an interrupt clears the gate; handler exit sets it.
// RQ5: Set-gate and clear-gate instructions write the gate bit directly.
// RQ6: Bit 6 is the copy bit for capture and deposit instructions.
// RQ7: Bit 5 holds half carry from the ALU.
// RQ8: Bit 4 is always negative XOR overflow.
// RQ9: Bit 3 holds two's complement overflow.
// RQ10: Bit 2 holds the negative result flag.
// RQ11: Bit 1 holds the zero result flag.
// RQ12: Bit 0 holds the carry flag.
// RQ13: Register file offers 8/16-bit reads with 8/16-bit write-back.
// RQ14: Registers appear at data addresses 0x00 to 0x1F.
// RQ15: Pointer accesses may target registers or data memory.
// RQ16: Registers 0x1A..0x1F form three low-byte-first pointers.
// RQ17: Pointers support displacement, post-increment and pre-decrement.
// RQ18: Stack grows downward; stack pointer marks the top.
// RQ19: Push lowers stack pointer by one, calls and interrupts by two.
// RQ20: Pop raises stack pointer by one, returns by two.
// RQ21: Stack pointer is I/O 0x3E high and 0x3D low, reset zero.
// RQ22: Software loads the stack pointer above 0x60 before use.
// RQ23: Push writes then decrements; pop increments then reads (stack_addr_o gives SP+1 only for one-byte pops, SP for two-byte pops).
module cfrs_core (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// ALU operand reads
	input wire logic [4:0] rd_addr_a_i,
	input wire logic [4:0] rd_addr_b_i,
	output logic [7:0] rd_data_a_o,
	output logic [7:0] rd_data_b_o,
	output logic [15:0] rd_word_a_o,
	// Write-back
	input wire cfrs_pkg::cfrs_wb_t wb_kind_i,
	input wire logic [4:0] wb_addr_i,
	input wire logic [15:0] wb_data_i,
	// ALU flags
	input wire logic alu_upd_i,
	input wire logic [7:0] alu_mask_i,
	input wire logic [7:0] alu_flags_i,
	// Flag instructions
	input wire logic gate_set_i,
	input wire logic gate_clr_i,
	input wire logic irq_taken_i,
	input wire logic handler_exit_instr_i,
	input wire logic flag_capture_instr_i,
	input wire logic flag_deposit_instr_i,
	input wire logic [4:0] bit_reg_i,
	input wire logic [2:0] bit_sel_i,
	// Interrupt gating
	input wire logic irq_request_i,
	output logic irq_allowed_o,
	// I/O space access
	input wire logic io_wr_i,
	input wire logic [5:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic io_hit_o,
	// Data space access
	input wire logic ds_wr_i,
	input wire logic [15:0] ds_addr_i,
	input wire logic [7:0] ds_wdata_i,
	output logic [7:0] ds_rdata_o,
	output logic ds_hit_o,
	// Pointer addressing
	input wire logic ptr_use_i,
	input wire logic [1:0] ptr_sel_i,
	input wire cfrs_pkg::cfrs_pmode_t ptr_mode_i,
	input wire logic [5:0] ptr_disp_i,
	output logic [15:0] ptr_addr_o,
	// Stack
	input wire cfrs_pkg::cfrs_spop_t sp_op_i,
	output logic [15:0] sp_o,
	output logic [15:0] stack_addr_o,
	// Status
	output logic [7:0] flags_o
);
	import cfrs_pkg::*;
	logic [7:0] gpr_reg [0:31];
	logic [7:0] flags;
	logic [15:0] sp;
	logic io_flags_wr;
	logic io_spl_wr;
	logic io_sph_wr;
	logic ds_gpr_wr;
	logic [4:0] ds_idx;
	logic [4:0] ptr_base;
	logic [15:0] ptr_val;
	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;
	logic ptr_wb;
	logic [15:0] ptr_wb_val;
	logic copy_bit;
	logic [7:0] dep_val;
	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic gpr_space(input logic [15:0] addr);
		gpr_space = (addr <= {8'h00, `CFRS_GPR_LAST});
	endfunction
	function automatic logic [15:0] pair_of(input logic [4:0] base);
		pair_of = {gpr_reg[base | 5'h01], gpr_reg[base & 5'h1e]};
	endfunction
	// ****************************************
	// I/O decode
	// ****************************************
	assign io_flags_wr = io_wr_i && (io_addr_i == `CFRS_IO_FLAGS);
	assign io_spl_wr = io_wr_i && (io_addr_i == `CFRS_IO_SP_LOW); // see RQ21
	assign io_sph_wr = io_wr_i && (io_addr_i == `CFRS_IO_SP_HIGH); // see RQ21
	assign io_hit_o = (io_addr_i == `CFRS_IO_FLAGS) || (io_addr_i == `CFRS_IO_SP_LOW)
		|| (io_addr_i == `CFRS_IO_SP_HIGH);
	assign io_rdata_o = (io_addr_i == `CFRS_IO_FLAGS) ? flags :
		(io_addr_i == `CFRS_IO_SP_HIGH) ? sp[15:8] :
		(io_addr_i == `CFRS_IO_SP_LOW) ? sp[7:0] : 8'h00;
	// ****************************************
	// Data space window onto the registers
	// ****************************************
	assign ds_hit_o = gpr_space(ds_addr_i); // see RQ14, see RQ15
	assign ds_idx = ds_addr_i[4:0];
	assign ds_gpr_wr = ds_wr_i && ds_hit_o; // see RQ14
	assign ds_rdata_o = ds_hit_o ? gpr_reg[ds_idx] : 8'h00;
	// ****************************************
	// Pointer pairs
	// ****************************************
	assign ptr_base = (ptr_sel_i == 2'h0) ? `CFRS_PTR_X :
		(ptr_sel_i == 2'h1) ? `CFRS_PTR_Y : `CFRS_PTR_Z;
	// Process, not assign, so register writes retrigger the pair read
	always_comb begin
		ptr_val = pair_of(ptr_base); // see RQ16
	end
	assign ptr_inc = ptr_val + 16'h0001;
	assign ptr_dec = ptr_val - 16'h0001;
	always_comb begin
		ptr_addr_o = ptr_val;
		ptr_wb = 1'b0;
		ptr_wb_val = ptr_val;
		unique case (ptr_mode_i)
			CFRS_PM_DISP: begin
				ptr_addr_o = ptr_val + {10'h000, ptr_disp_i}; // see RQ17
			end
			CFRS_PM_POSTINC: begin
				ptr_wb = ptr_use_i; // see RQ17
				ptr_wb_val = ptr_inc;
			end
			CFRS_PM_PREDEC: begin
				ptr_addr_o = ptr_dec; // see RQ17
				ptr_wb = ptr_use_i;
				ptr_wb_val = ptr_dec;
			end
			default: ptr_addr_o = ptr_val;
		endcase
	end
	// ****************************************
	// Operand reads and bit copy
	// ****************************************
	assign rd_data_a_o = gpr_reg[rd_addr_a_i]; // see RQ13
	assign rd_data_b_o = gpr_reg[rd_addr_b_i]; // see RQ13
	always_comb begin
		rd_word_a_o = pair_of(rd_addr_a_i); // see RQ13
	end
	assign copy_bit = gpr_reg[bit_reg_i][bit_sel_i]; // see RQ6
	always_comb begin
		dep_val = gpr_reg[bit_reg_i];
		dep_val[bit_sel_i] = flags[`CFRS_BIT_COPY]; // see RQ6
	end
	// ****************************************
	// Register file write ports
	// ****************************************
	// Priority: write-back, then data space, then pointer update, then deposit
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_gpr
			logic [4:0] idx;
			logic [7:0] nxt;
			logic we;
			assign idx = 5'(gi);
			always_comb begin
				we = 1'b1;
				nxt = gpr_reg[gi];
				if (wb_kind_i == CFRS_WB_BYTE && wb_addr_i == idx) begin
					nxt = wb_data_i[7:0]; // see RQ13
				end else if (wb_kind_i == CFRS_WB_WORD && (wb_addr_i & 5'h1e) == idx) begin
					nxt = wb_data_i[7:0]; // see RQ13
				end else if (wb_kind_i == CFRS_WB_WORD && (wb_addr_i | 5'h01) == idx) begin
					nxt = wb_data_i[15:8]; // see RQ13
				end else if (ds_gpr_wr && ds_idx == idx) begin
					nxt = ds_wdata_i; // see RQ14
				end else if (ptr_wb && ptr_base == idx) begin
					nxt = ptr_wb_val[7:0]; // see RQ16
				end else if (ptr_wb && (ptr_base | 5'h01) == idx) begin
					nxt = ptr_wb_val[15:8]; // see RQ16
				end else if (flag_deposit_instr_i && bit_reg_i == idx) begin
					nxt = dep_val; // see RQ6
				end else begin
					we = 1'b0;
				end
			end
			always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					gpr_reg[gi] <= 8'h00;
				end else if (we) begin
					gpr_reg[gi] <= nxt;
				end
			end
		end
	endgenerate
	// ****************************************
	// Flags and stack
	// ****************************************
	cfrs_flags u_flags (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.alu_upd_i(alu_upd_i),
		.alu_mask_i(alu_mask_i),
		.alu_flags_i(alu_flags_i),
		.io_wr_i(io_flags_wr),
		.io_data_i(io_wdata_i),
		.gate_set_i(gate_set_i),
		.gate_clr_i(gate_clr_i),
		.irq_taken_i(irq_taken_i),
		.handler_exit_instr_i(handler_exit_instr_i),
		.flag_capture_instr_i(flag_capture_instr_i),
		.copy_bit_i(copy_bit),
		.flags_o(flags)
	);
	cfrs_stack u_stack (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.sp_op_i(sp_op_i),
		.wr_low_i(io_spl_wr),
		.wr_high_i(io_sph_wr),
		.wr_data_i(io_wdata_i),
		.sp_o(sp),
		.stack_addr_o(stack_addr_o)
	);
	// Gate bit masks every request; clear-gate acts in its own cycle
	assign irq_allowed_o = irq_request_i && flags[`CFRS_BIT_GATE] && !gate_clr_i; // see RQ3
	assign sp_o = sp;
	assign flags_o = flags;
endmodule

// ---- tb/cfrs_core_asserts.sv ----
`timescale 1ns/1ps
module cfrs_core_asserts (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic alu_upd_i,
	input wire logic [7:0] alu_mask_i,
	input wire logic [7:0] alu_flags_i,
	input wire logic gate_set_i,
	input wire logic gate_clr_i,
	input wire logic irq_taken_i,
	input wire logic handler_exit_instr_i,
	input wire logic irq_request_i,
	input wire logic irq_allowed_o,
	input wire logic io_wr_i,
	input wire logic [5:0] io_addr_i,
	input wire cfrs_pkg::cfrs_spop_t sp_op_i,
	input wire logic [15:0] sp_o,
	input wire logic [15:0] stack_addr_o,
	input wire logic [7:0] flags_o
);
	import cfrs_pkg::*;
	logic fl_wr;
	logic sp_wr;
	assign fl_wr = io_wr_i && io_addr_i == 6'h3f;
	assign sp_wr = io_wr_i && (io_addr_i == 6'h3d || io_addr_i == 6'h3e);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	property p_sign; flags_o[4] == (flags_o[2] ^ flags_o[3]); endproperty
	a_sign: assert property (p_sign) else $error("sign bit wrong");
	property p_irq; irq_allowed_o == (irq_request_i && flags_o[7] && !gate_clr_i); endproperty
	a_irq: assert property (p_irq) else $error("irq gating wrong");
	property p_gclr; irq_taken_i || gate_clr_i |=> !flags_o[7]; endproperty
	a_gclr: assert property (p_gclr) else $error("gate not cleared");
	property p_gset; (handler_exit_instr_i || gate_set_i) && !irq_taken_i && !gate_clr_i
		|=> flags_o[7]; endproperty
	a_gset: assert property (p_gset) else $error("gate not set");
	property p_alu; alu_upd_i && !fl_wr |=> (flags_o[3:0] & $past(alu_mask_i[3:0]))
		== ($past(alu_flags_i[3:0]) & $past(alu_mask_i[3:0])); endproperty
	a_alu: assert property (p_alu) else $error("alu flags lost");
	property p_push1; sp_op_i == CFRS_SP_PUSH1 && !sp_wr
		|-> stack_addr_o == sp_o ##1 sp_o == $past(sp_o) - 16'h0001; endproperty
	a_push1: assert property (p_push1) else $error("push wrong");
	property p_pop1; sp_op_i == CFRS_SP_POP1 && !sp_wr
		|-> stack_addr_o == sp_o + 16'h0001 ##1 sp_o == $past(stack_addr_o); endproperty
	a_pop1: assert property (p_pop1) else $error("pop wrong");
	property p_pop2; sp_op_i == CFRS_SP_POP2 && !sp_wr |=> sp_o == $past(sp_o) + 16'h0002;
	endproperty
	a_pop2: assert property (p_pop2) else $error("return pop wrong");
	c_push: cover property (sp_op_i == CFRS_SP_PUSH1);
	c_irq: cover property (irq_allowed_o);
	c_taken: cover property (irq_taken_i);
endmodule
bind cfrs_core cfrs_core_asserts u_cfrs_core_asserts (.clk_sys_i, .reset_n_i, .alu_upd_i,
	.alu_mask_i, .alu_flags_i, .gate_set_i, .gate_clr_i, .irq_taken_i, .handler_exit_instr_i,
	.irq_request_i, .irq_allowed_o, .io_wr_i, .io_addr_i, .sp_op_i, .sp_o, .stack_addr_o,
	.flags_o);

// ---- tb/cfrs_alu_model.sv ----
`timescale 1ns/1ps
module cfrs_alu_model (
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	output logic [7:0] mask_o,
	output logic [7:0] flags_o
);
	logic [8:0] sum;
	logic [4:0] low;
	assign sum = {1'b0, a_i} + {1'b0, b_i};
	assign low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
	assign mask_o = 8'h3f;
	// Add flags only; gate and copy bits never saved or restored here
	assign flags_o = {2'b00, low[4], 1'b0, a_i[7] == b_i[7] && sum[7] != a_i[7],
		sum[7], sum[7:0] == 8'h00, sum[8]};
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import cfrs_pkg::*;
	logic clk_sys_i = '0, reset_n_i = '0, alu_upd_i = '0, gate_set_i = '0, gate_clr_i = '0;
	logic irq_taken_i = '0, handler_exit_instr_i = '0, flag_capture_instr_i = '0;
	logic flag_deposit_instr_i = '0, irq_request_i = '0, io_wr_i = '0, ds_wr_i = '0;
	logic ptr_use_i = '0, irq_allowed_o, io_hit_o, ds_hit_o;
	logic [1:0] ptr_sel_i = '0;
	logic [2:0] bit_sel_i = '0;
	logic [4:0] rd_addr_a_i = '0, rd_addr_b_i = '0, wb_addr_i = '0, bit_reg_i = '0;
	logic [5:0] io_addr_i = '0, ptr_disp_i = '0;
	logic [7:0] io_wdata_i = '0, ds_wdata_i = '0, op_a = '0, op_b = '0, alu_mask_i, alu_flags_i;
	logic [7:0] rd_data_a_o, rd_data_b_o, io_rdata_o, ds_rdata_o, flags_o;
	logic [15:0] wb_data_i = '0, ds_addr_i = '0, rd_word_a_o, ptr_addr_o, sp_o, stack_addr_o;
	logic [15:0] exp_sp;
	cfrs_wb_t wb_kind_i = CFRS_WB_NONE;
	cfrs_pmode_t ptr_mode_i = CFRS_PM_DISP;
	cfrs_spop_t sp_op_i = CFRS_SP_HOLD;
	cfrs_spop_t sp_ops [4] = '{CFRS_SP_PUSH1, CFRS_SP_PUSH2, CFRS_SP_POP1, CFRS_SP_POP2};
	logic [15:0] sp_dlt [4] = '{16'hffff, 16'hfffe, 16'h0001, 16'h0002};
	int error_cnt = 0, checks = 0, cyc = 0;
	cfrs_core u_cfrs_core (.clk_sys_i, .reset_n_i, .rd_addr_a_i, .rd_addr_b_i, .rd_data_a_o,
		.rd_data_b_o, .rd_word_a_o, .wb_kind_i, .wb_addr_i, .wb_data_i, .alu_upd_i, .alu_mask_i,
		.alu_flags_i, .gate_set_i, .gate_clr_i, .irq_taken_i, .handler_exit_instr_i,
		.flag_capture_instr_i, .flag_deposit_instr_i, .bit_reg_i, .bit_sel_i, .irq_request_i,
		.irq_allowed_o, .io_wr_i, .io_addr_i, .io_wdata_i, .io_rdata_o, .io_hit_o, .ds_wr_i,
		.ds_addr_i, .ds_wdata_i, .ds_rdata_o, .ds_hit_o, .ptr_use_i, .ptr_sel_i, .ptr_mode_i,
		.ptr_disp_i, .ptr_addr_o, .sp_op_i, .sp_o, .stack_addr_o, .flags_o);
	cfrs_alu_model u_cfrs_alu_model (.a_i(op_a), .b_i(op_b), .mask_o(alu_mask_i),
		.flags_o(alu_flags_i));
	always #50 clk_sys_i = ~clk_sys_i;
	task automatic report_and_stop;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, ex, got);
		end
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask
	task automatic io_w(input logic [5:0] a, input logic [7:0] d);
		io_addr_i = a;
		io_wdata_i = d;
		pulse(io_wr_i);
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial begin
		tick(6);
		reset_n_i = 1'b1;
		io_addr_i = 6'h3f;
		#1 chk("flags rst", 16'h0000, io_rdata_o);
		io_addr_i = 6'h3c;
		#1 chk("io miss", 16'h0000, io_hit_o);
		io_w(6'h3e, 8'h10);
		io_w(6'h3d, 8'h80);
		chk("sp load", 16'h1080, sp_o);
		#1 chk("sp low rd", 16'h0080, io_rdata_o);
		exp_sp = 16'h1080;
		foreach (sp_ops[i]) begin
			sp_op_i = sp_ops[i];
			#1 chk("stk addr", exp_sp + (sp_ops[i] == CFRS_SP_POP1), stack_addr_o);
			tick();
			exp_sp = exp_sp + sp_dlt[i];
			chk("sp step", exp_sp, sp_o);
		end
		sp_op_i = CFRS_SP_HOLD;
		op_a = 8'h7f;
		op_b = 8'h01;
		pulse(alu_upd_i);
		chk("flags ovf", 16'h002c, flags_o);
		op_a = 8'hff;
		pulse(alu_upd_i);
		chk("flags carry", 16'h0023, flags_o);
		irq_request_i = 1'b1;
		#1 chk("irq off", 16'h0000, irq_allowed_o);
		io_w(6'h3f, 8'hff);
		chk("flags io", 16'h00ef, flags_o);
		pulse(irq_taken_i);
		chk("gate taken", 16'h006f, flags_o);
		chk("irq blocked", 16'h0000, irq_allowed_o);
		pulse(handler_exit_instr_i);
		chk("gate exit", 16'h00ef, flags_o);
		chk("irq pass", 16'h0001, irq_allowed_o);
		pulse(gate_clr_i);
		chk("gate clr", 16'h006f, flags_o);
		pulse(gate_set_i);
		chk("gate set", 16'h00ef, flags_o);
		wb_kind_i = CFRS_WB_WORD;
		wb_addr_i = 5'h1a;
		wb_data_i = 16'h1234;
		tick();
		wb_kind_i = CFRS_WB_NONE;
		ds_addr_i = 16'h001b;
		rd_addr_a_i = 5'h1a;
		ptr_disp_i = 6'h05;
		#1 chk("x high", 16'h0012, ds_rdata_o);
		chk("x word", 16'h1234, rd_word_a_o);
		chk("disp", 16'h1239, ptr_addr_o);
		ptr_mode_i = CFRS_PM_PREDEC;
		pulse(ptr_use_i);
		chk("predec", 16'h1233, rd_word_a_o);
		ptr_mode_i = CFRS_PM_POSTINC;
		#1 chk("postinc ad", 16'h1233, ptr_addr_o);
		pulse(ptr_use_i);
		chk("postinc", 16'h1234, rd_word_a_o);
		ds_addr_i = 16'h0005;
		ds_wdata_i = 8'ha5;
		pulse(ds_wr_i);
		ds_addr_i = 16'h0020;
		ds_wdata_i = 8'h00;
		pulse(ds_wr_i);
		rd_addr_b_i = 5'h05;
		chk("ds miss", 16'h0000, ds_hit_o);
		#1 chk("ds reg", 16'h00a5, rd_data_b_o);
		bit_reg_i = 5'h05;
		bit_sel_i = 3'h1;
		pulse(flag_capture_instr_i);
		chk("copy in", 16'h0000, flags_o[6]);
		bit_sel_i = 3'h7;
		pulse(flag_deposit_instr_i);
		chk("copy out", 16'h0025, rd_data_b_o);
		rd_addr_a_i = 5'h05;
		wb_kind_i = CFRS_WB_BYTE;
		wb_addr_i = 5'h1e;
		wb_data_i = 16'hbe3c;
		tick();
		wb_kind_i = CFRS_WB_NONE;
		ptr_sel_i = 2'h2;
		ptr_mode_i = CFRS_PM_DISP;
		ds_addr_i = 16'h001e;
		io_addr_i = 6'h3e;
		#1 chk("rd a", 16'h0025, rd_data_a_o);
		chk("byte wb", 16'h003c, ds_rdata_o);
		chk("ds hit", 16'h0001, ds_hit_o);
		chk("z disp", 16'h0041, ptr_addr_o);
		chk("io hit", 16'h0001, io_hit_o);
		chk("sp high rd", 16'h0010, io_rdata_o);
		report_and_stop();
	end
endmodule
